// ### rtl/sipc_cmd_decoder.v
// command decoder for scroll pointer, reduced-colour mode, pixel format and continue-write
`timescale 1ns/10ps
`include "sipc_defines.vh"

// What this block does
// - scroll pointer has two bytes: bit 8 in byte one bit 0, low eight next.
// - pointed memory line is first scrolled line after the top fixed region.
// - new pointer takes effect only at next frame start, avoiding tearing.
// - pointer zero after hardware reset, unchanged by software reset.
// - reduced-colour exit restores full colour and normal frame rate.
// - reduced-colour exit does nothing when already out of that mode.
// - reduced-colour entry shows eight colours from each primary's top bit.
// - while reduced, panel refreshes at the eight-colour frame rate.
// - reduction applies cleanly at a frame boundary, no artefact.
// - reduced mode stays until the exit command arrives.
// - reduced mode off after hardware and software reset.
// - format byte: bits 6..4 rgb port, bits 2..0 command port, 7 and 3 zero.
// - command-port code 101 is 16 bits per pixel, 110 is 18 bits.
// - rgb-port code 101 is 65k colours, 110 is 262k colours.
// - both pixel widths route incoming pixels through the lookup table.
// - format defaults 66h on hardware reset, unchanged by software reset.
// - opcode 3ch is decoded as continue-write followed by pixel bytes.
// - continue-write resumes after the previous write's last pixel.
// - line-order bit picks refresh direction; scroll mapping follows it.
module sipc_cmd_decoder (
  input  wire       clk,
  input  wire       rst,
  input  wire       sw_reset,
  input  wire       write_strobe,
  input  wire       cmd_param_select,
  input  wire [7:0] bus_data,
  input  wire       frame_start,
  input  wire       refresh_line_order,
  input  wire [8:0] scan_line,
  input  wire [8:0] top_fixed_lines,
  input  wire [8:0] scroll_area_lines,
  input  wire [5:0] pix_red,
  input  wire [5:0] pix_green,
  input  wire [5:0] pix_blue,
  output reg  [8:0] scroll_line_pointer,
  output reg  [8:0] mem_line,
  output reg        reduced_color,
  output reg        reduced_frame_rate,
  output reg  [5:0] disp_red,
  output reg  [5:0] disp_green,
  output reg  [5:0] disp_blue,
  output reg  [7:0] pixel_format,
  output reg        cmd_16bpp,
  output reg        rgb_65k,
  output reg        lut_enable,
  output reg        cont_write_active,
  output reg        pixel_byte_valid,
  output reg  [7:0] pixel_byte
);

  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_PTR_HI = 4'b0010;
  localparam [3:0] ST_PTR_LO = 4'b0100;
  localparam [3:0] ST_FMT    = 4'b1000;

  // collapse a 6-bit primary onto its msb for eight-colour output
  function [5:0] reduce6;
    input [5:0] v;
    begin
      reduce6 = {6{v[5]}};
    end
  endfunction

  // true when a three-bit colour format field holds the given code
  function fmt_is;
    input [2:0] fld;
    input [2:0] code;
    begin
      fmt_is = (fld == code);
    end
  endfunction

  reg  [3:0] state_r;
  reg  [3:0] state_nxt;
  reg        strobe_d_r;
  reg        ptr_msb_r;
  reg  [8:0] ptr_pending_r;
  reg        ptr_dirty_r;
  reg        rc_pending_r;
  reg        stream_r;
  reg  [8:0] rel_line;
  reg  [9:0] sum_line;
  reg  [8:0] scroll_off;
  reg  [8:0] sline;
  reg        in_scroll;

  wire strobe_rise = write_strobe & ~strobe_d_r;
  wire take_op     = strobe_rise & ~cmd_param_select;
  wire take_par    = strobe_rise & cmd_param_select;
  wire ptr_load    = take_par & (state_r == ST_PTR_LO);
  wire fmt_load    = take_par & (state_r == ST_FMT);
  wire op_is_cont  = (bus_data == `SIPC_OP_CONT_WRITE);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_PTR_HI, ST_PTR_LO, ST_FMT:
      begin
        if (take_op)
        begin
          case (bus_data)
            `SIPC_OP_SCROLL_START: state_nxt = ST_PTR_HI;
            `SIPC_OP_PIXFMT:       state_nxt = ST_FMT;
            default:               state_nxt = ST_IDLE;
          endcase
        end
        else if (take_par)
        begin
          case (state_r)
            ST_PTR_HI: state_nxt = ST_PTR_LO;
            default:   state_nxt = ST_IDLE;
          endcase
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // scroll mapping; direction follows the refresh order input
  always @*
  begin
    sline      = scan_line;
    rel_line   = 9'h000;
    sum_line   = 10'h000;
    scroll_off = 9'h000;
    in_scroll  = 1'b0;
    // bottom-to-top refresh mirrors the scan line inside the scroll area
    if (refresh_line_order)
      sline = scroll_area_lines - 9'h001 - scan_line;
    // compare at ten bits so top plus area cannot wrap
    in_scroll = ({1'b0, sline} >= {1'b0, top_fixed_lines})
             && ({1'b0, sline} < ({1'b0, top_fixed_lines} + {1'b0, scroll_area_lines}));
    if (in_scroll)
    begin
      rel_line   = sline - top_fixed_lines;
      scroll_off = scroll_line_pointer - top_fixed_lines;
      sum_line   = {1'b0, rel_line} + {1'b0, scroll_off};
      // one wrap suffices while the host keeps the pointer in the area
      if (sum_line >= {1'b0, scroll_area_lines})
        sum_line = sum_line - {1'b0, scroll_area_lines};
      sum_line = sum_line + {1'b0, top_fixed_lines};
    end
    else
    begin
      sum_line = {1'b0, sline};
    end
  end

  // strobe history and command sequencing
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_d_r <= 1'b0;
      state_r    <= ST_IDLE;
    end
    else
    begin
      strobe_d_r <= write_strobe;
      if (sw_reset)
        state_r <= ST_IDLE;
      else
        state_r <= state_nxt;
    end
  end

  // pointer bytes are staged and applied only when a new scan begins
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_msb_r           <= 1'b0;
      ptr_pending_r       <= `SIPC_PTR_RST;
      ptr_dirty_r         <= 1'b0;
      scroll_line_pointer <= `SIPC_PTR_RST;
    end
    else if (sw_reset)
    begin
      // pointer survives a software reset
      ptr_dirty_r <= ptr_dirty_r;
    end
    else
    begin
      if (take_par && state_r == ST_PTR_HI)
        ptr_msb_r <= bus_data[`SIPC_PTR_MSB_POS];
      if (frame_start && ptr_dirty_r)
        scroll_line_pointer <= ptr_pending_r;
      // a pointer completed in the frame-start cycle waits for the next scan
      if (ptr_load)
      begin
        ptr_pending_r <= {ptr_msb_r, bus_data};
        ptr_dirty_r   <= 1'b1;
      end
      else if (frame_start)
      begin
        ptr_dirty_r <= 1'b0;
      end
    end
  end

  // reduced-colour mode: requested at once, shown from the next scan
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rc_pending_r       <= 1'b0;
      reduced_color      <= 1'b0;
      reduced_frame_rate <= 1'b0;
    end
    else if (sw_reset)
    begin
      rc_pending_r       <= 1'b0;
      reduced_color      <= 1'b0;
      reduced_frame_rate <= 1'b0;
    end
    else
    begin
      if (take_op && bus_data == `SIPC_OP_RC_ENTRY)
        rc_pending_r <= 1'b1;
      else if (take_op && bus_data == `SIPC_OP_RC_EXIT)
        rc_pending_r <= 1'b0;
      // switching between scans keeps any frame from showing a mixed palette
      if (frame_start)
      begin
        reduced_color      <= rc_pending_r;
        reduced_frame_rate <= rc_pending_r;
      end
    end
  end

  // interface pixel format; kept across a software reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pixel_format <= `SIPC_PIXFMT_RST;
      cmd_16bpp    <= 1'b0;
      rgb_65k      <= 1'b0;
    end
    else if (!sw_reset && fmt_load)
    begin
      pixel_format <= bus_data & `SIPC_FMT_MASK;
      cmd_16bpp    <= fmt_is(bus_data[`SIPC_CMD_FMT_HI:`SIPC_CMD_FMT_LO],
                             `SIPC_FMT_16BPP);
      rgb_65k      <= fmt_is(bus_data[`SIPC_RGB_FMT_HI:`SIPC_RGB_FMT_LO],
                             `SIPC_FMT_16BPP);
    end
  end

  // 16 and 18 bpp both go through the lookup table; other codes bypass it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lut_enable <= 1'b1;
    end
    else
    begin
      lut_enable <= fmt_is(pixel_format[`SIPC_CMD_FMT_HI:`SIPC_CMD_FMT_LO], `SIPC_FMT_16BPP)
                 || fmt_is(pixel_format[`SIPC_CMD_FMT_HI:`SIPC_CMD_FMT_LO], `SIPC_FMT_18BPP);
    end
  end

  // continue-write stream; any other opcode ends it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stream_r          <= 1'b0;
      cont_write_active <= 1'b0;
      pixel_byte_valid  <= 1'b0;
      pixel_byte        <= 8'h00;
    end
    else
    begin
      pixel_byte_valid <= 1'b0;
      if (sw_reset)
      begin
        stream_r          <= 1'b0;
        cont_write_active <= 1'b0;
      end
      else if (take_op)
      begin
        stream_r          <= op_is_cont;
        cont_write_active <= op_is_cont;
      end
      else if (take_par && stream_r)
      begin
        // window counters outside keep their place between writes
        pixel_byte_valid <= 1'b1;
        pixel_byte       <= bus_data;
      end
    end
  end

  // memory line for the scan line, one cycle behind
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_line <= 9'h000;
    end
    else
    begin
      mem_line <= sum_line[8:0];
    end
  end

  // display path; uses the mode shown during the previous cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      disp_red   <= 6'h00;
      disp_green <= 6'h00;
      disp_blue  <= 6'h00;
    end
    else
    begin
      disp_red   <= reduced_color ? reduce6(pix_red) : pix_red;
      disp_green <= reduced_color ? reduce6(pix_green) : pix_green;
      disp_blue  <= reduced_color ? reduce6(pix_blue) : pix_blue;
    end
  end

endmodule

// ### include/sipc_defines.vh
// constants for the scroll, reduced-colour and pixel-format command decoder
`ifndef SIPC_DEFINES_VH
`define SIPC_DEFINES_VH

`define SIPC_OP_SCROLL_START  8'h37
`define SIPC_OP_RC_EXIT       8'h38
`define SIPC_OP_RC_ENTRY      8'h39
`define SIPC_OP_PIXFMT        8'h3a
`define SIPC_OP_MEM_WRITE     8'h2c
`define SIPC_OP_CONT_WRITE    8'h3c

`define SIPC_PIXFMT_RST       8'h66
`define SIPC_PTR_RST          9'h000
`define SIPC_PTR_MSB_POS      0
`define SIPC_RGB_FMT_HI       6
`define SIPC_RGB_FMT_LO       4
`define SIPC_CMD_FMT_HI       2
`define SIPC_CMD_FMT_LO       0
`define SIPC_FMT_MASK         8'h77
`define SIPC_FMT_16BPP        3'b101
`define SIPC_FMT_18BPP        3'b110
`define SIPC_LINE_ORDER_POS   4

`endif

// ### testbench/sipc_props.sv
// assertion checker for the scroll, reduced-colour and pixel-format decoder
`timescale 1ns/10ps
module sipc_props (
  input wire       clk, rst, sw_reset, cmd_param_select, frame_start,
  input wire [5:0] pix_red, pix_green, pix_blue, disp_red, disp_green, disp_blue,
  input wire [8:0] scroll_line_pointer,
  input wire [7:0] pixel_format,
  input wire       reduced_color, reduced_frame_rate, cmd_16bpp, rgb_65k, lut_enable,
  input wire       cont_write_active, pixel_byte_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  fmt_rsvd_a: assert property (pixel_format[7] == 1'b0 && pixel_format[3] == 1'b0)
    else $error("reserved format bit set");
  cmd_16_a: assert property (cmd_16bpp == (pixel_format[2:0] == 3'b101))
    else $error("command-port width decode wrong");
  rgb_65_a: assert property (rgb_65k == (pixel_format[6:4] == 3'b101))
    else $error("rgb-port colour decode wrong");
  lut_map_a: assert property (1'b1 |=> lut_enable ==
    ($past(pixel_format[2:0]) == 3'b101 || $past(pixel_format[2:0]) == 3'b110))
    else $error("lookup enable wrong");
  ptr_hold_a: assert property (!frame_start |=> $stable(scroll_line_pointer))
    else $error("pointer moved outside frame start");
  rc_hold_a: assert property (!frame_start && !sw_reset |=> $stable(reduced_color))
    else $error("colour mode moved outside frame start");
  rate_a: assert property (reduced_frame_rate == reduced_color)
    else $error("frame rate does not follow colour mode");
  swr_a: assert property (sw_reset |=> !reduced_color && !cont_write_active)
    else $error("software reset left mode set");
  dim_a: assert property (reduced_color |=> disp_red == {6{$past(pix_red[5])}} &&
    disp_green == {6{$past(pix_green[5])}} && disp_blue == {6{$past(pix_blue[5])}})
    else $error("reduced colour output wrong");
  full_a: assert property (!reduced_color |=> disp_red == $past(pix_red) &&
    disp_green == $past(pix_green) && disp_blue == $past(pix_blue))
    else $error("full colour output wrong");
  pix_a: assert property (pixel_byte_valid |-> $past(cmd_param_select) ##1 !pixel_byte_valid)
    else $error("pixel byte pulse wrong");
endmodule
bind sipc_cmd_decoder sipc_props chk (.clk, .rst, .sw_reset, .cmd_param_select, .frame_start,
  .pix_red, .pix_green, .pix_blue, .disp_red, .disp_green, .disp_blue, .scroll_line_pointer,
  .pixel_format, .reduced_color, .reduced_frame_rate, .cmd_16bpp, .rgb_65k, .lut_enable,
  .cont_write_active, .pixel_byte_valid);

// ### testbench/sipc_host_model.sv
// host model writing opcode and parameter bytes on the command port
`timescale 1ns/10ps
module sipc_host_model (
  input  wire        clk,
  output logic       write_strobe = 1'b0,
  output logic       cmd_param_select = 1'b0,
  output logic [7:0] bus_data = 8'h00
);
  // pointers sent stay inside the scroll region; format bytes keep bits 7 and 3 at zero
  // except where a bench scenario means to break that
  task automatic send(input logic sel, input logic [7:0] d);
    @(negedge clk);
    cmd_param_select = sel;
    bus_data = d;
    write_strobe = 1'b1;
    @(negedge clk);
    write_strobe = 1'b0;
    // released bus shows the inverse, so a stale byte is never taken for a match
    bus_data = ~d;
  endtask
endmodule

// ### testbench/scroll_idle_pixfmt_cmds_tb_top.sv
// self-checking bench for the scroll, reduced-colour and pixel-format decoder
`timescale 1ns/10ps
`define chk(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module scroll_idle_pixfmt_cmds_tb_top;
  logic       clk = 1'b0, rst = 1'b1, sw_reset = 1'b0, frame_start = 1'b0;
  logic [5:0] pix_red = 6'h20, pix_green = 6'h1f, pix_blue = 6'h3f;
  wire        write_strobe, cmd_param_select;
  wire  [7:0] bus_data, pixel_format, pixel_byte;
  wire  [8:0] scroll_line_pointer, mem_line;
  wire        reduced_color, reduced_frame_rate, cmd_16bpp, rgb_65k, lut_enable;
  wire        cont_write_active, pixel_byte_valid;
  wire  [5:0] disp_red, disp_green, disp_blue;
  int         failures = 0, n_tests = 0, cyc = 0, nv = 0;
  logic [7:0] got = 8'h00;
  logic       line_order = 1'b0;
  logic [8:0] scan = 9'h000;
  logic [7:0] fi [4] = '{8'h55, 8'h66, 8'hff, 8'h00};
  logic [7:0] fe [4] = '{8'h55, 8'h66, 8'h77, 8'h00};
  sipc_host_model host (.clk, .write_strobe, .cmd_param_select, .bus_data);
  sipc_cmd_decoder dut (.clk, .rst, .sw_reset, .write_strobe, .cmd_param_select, .bus_data,
    .frame_start, .refresh_line_order(line_order), .scan_line(scan), .top_fixed_lines(9'h000),
    .scroll_area_lines(9'h186), .pix_red, .pix_green, .pix_blue, .scroll_line_pointer,
    .mem_line, .reduced_color, .reduced_frame_rate, .disp_red, .disp_green, .disp_blue,
    .pixel_format, .cmd_16bpp, .rgb_65k, .lut_enable, .cont_write_active, .pixel_byte_valid,
    .pixel_byte);
  initial forever #20 clk = ~clk;
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // the whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      give_verdict();
    end
    if (pixel_byte_valid === 1'b1)
    begin
      got <= pixel_byte;
      nv <= nv + 1;
    end
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame();
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    idle(2);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.send(1'b0, op);
    frame();
  endtask
  initial
  begin
    idle(16);
    rst = 1'b0;
    idle(2);
    `chk(scroll_line_pointer, 9'h000)
    `chk(pixel_format, 8'h66)
    `chk(reduced_color, 1'b0)
    for (int i = 0; i < 4; i++)
    begin
      host.send(1'b0, 8'h3a);
      host.send(1'b1, fi[i]);
      idle(3);
      `chk(pixel_format, fe[i])
      `chk(cmd_16bpp, fe[i][2:0] == 3'b101)
      `chk(rgb_65k, fe[i][6:4] == 3'b101)
      `chk(lut_enable, fe[i][2:0] == 3'b101 || fe[i][2:0] == 3'b110)
    end
    host.send(1'b0, 8'h37);
    host.send(1'b1, 8'h01);
    host.send(1'b1, 8'h23);
    host.send(1'b0, 8'h39);
    idle(3);
    `chk(scroll_line_pointer, 9'h000)
    `chk(reduced_color, 1'b0)
    frame();
    `chk(scroll_line_pointer, 9'h123)
    `chk(mem_line, 9'h123)
    line_order = 1'b1;
    idle(2);
    `chk(mem_line, 9'h122)
    line_order = 1'b0;
    scan = 9'h005;
    idle(2);
    `chk(mem_line, 9'h128)
    `chk({reduced_color, disp_red, disp_green, disp_blue}, {1'b1, 18'h3f03f})
    cmd(8'h38);
    `chk({reduced_color, disp_red, disp_green, disp_blue}, {1'b0, 18'h207ff})
    cmd(8'h38);
    `chk(reduced_color, 1'b0)
    cmd(8'h39);
    sw_reset = 1'b1;
    @(negedge clk);
    sw_reset = 1'b0;
    idle(2);
    `chk(reduced_color, 1'b0)
    `chk({scroll_line_pointer, pixel_format}, {9'h123, 8'h00})
    `chk(nv, 0)
    host.send(1'b0, 8'h3c);
    host.send(1'b1, 8'hab);
    host.send(1'b0, 8'h00);
    host.send(1'b1, 8'hcd);
    idle(2);
    `chk({nv[7:0], got, cont_write_active}, {8'h01, 8'hab, 1'b0})
    give_verdict();
  end
endmodule
